// File: hw/add_instruction_microsequencer.sv
`timescale 1ns/1ns
`default_nettype none
module add_instruction_microsequencer #(
  parameter int NREGS = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [15:0] mem_rd_data,
  output logic [15:0]      memory_address_latch,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [15:0]      mem_wr_data,
  output logic             mem_wr_oe,
  output logic [15:0]      instruction_holding_latch,
  output logic [4:0]       pipeline_step,
  output logic             illegal_opcode,
  output logic [15:0]      program_counter
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  add_seq_pkg::step_t step_q;
  add_seq_pkg::step_t step_d;
  logic [15:0] regs_q [NREGS];
  logic [15:0] hold_q;
  logic [15:0] mal_q;
  logic [15:0] ir_q;
  logic        illegal_q;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  wire [7:0]  op_f   = ir_q[add_seq_pkg::OP_MSB:add_seq_pkg::OP_LSB];
  wire [3:0]  first_register_field  = ir_q[add_seq_pkg::F1_MSB:add_seq_pkg::F1_LSB];
  wire [3:0]  second_register_field = ir_q[add_seq_pkg::F2_MSB:add_seq_pkg::F2_LSB];
  wire [3:0]  first_index_field     = first_register_field;
  wire [3:0]  second_index_field    = second_register_field;
  wire [15:0] short_imm = {12'h000, second_register_field};
  wire [15:0] r1_val    = regs_q[first_register_field];
  wire [15:0] r2_val    = regs_q[second_register_field];
  wire [15:0] pc_val    = regs_q[add_seq_pkg::PC_REG_IDX];
  wire [15:0] x1_val    = regs_q[first_index_field];
  wire [15:0] x2_val    = regs_q[second_index_field];

  // Memory sits on the microcycle clock and answers in the step that reads
  // it, so its data feeds the datapath directly; a two-flop stage here would
  // hand every read step the word from two addresses back
  wire [15:0] mem_in = mem_rd_data;

  // ---------------------------------------------------------------
  // Step decode
  // ---------------------------------------------------------------
  // Fetch routine, shared by every instruction
  wire st_fetch0   = (step_q == add_seq_pkg::S_FETCH0);
  wire st_fetch1   = (step_q == add_seq_pkg::S_FETCH1);
  wire st_decode   = (step_q == add_seq_pkg::S_DECODE);
  // Single-step routines
  wire st_rr_ex    = (step_q == add_seq_pkg::S_RR_EX);
  wire st_rs_ex    = (step_q == add_seq_pkg::S_RS_EX);
  // Register-to-memory-reference
  wire st_rm_addr  = (step_q == add_seq_pkg::S_RM_ADDR);
  wire st_rm_add   = (step_q == add_seq_pkg::S_RM_ADD);
  // Memory-to-memory
  wire st_mm_addr2 = (step_q == add_seq_pkg::S_MM_ADDR2);
  wire st_mm_ldq   = (step_q == add_seq_pkg::S_MM_LDQ);
  wire st_mm_addr1 = (step_q == add_seq_pkg::S_MM_ADDR1);
  wire st_mm_addq  = (step_q == add_seq_pkg::S_MM_ADDQ);
  wire st_mm_wr    = (step_q == add_seq_pkg::S_MM_WR);
  // Register-to-indexed-memory
  wire st_rx_pc    = (step_q == add_seq_pkg::S_RX_PC);
  wire st_rx_idx   = (step_q == add_seq_pkg::S_RX_IDX);
  wire st_rx_add   = (step_q == add_seq_pkg::S_RX_ADD);
  // Register-to-memory-immediate
  wire st_rmi_addr = (step_q == add_seq_pkg::S_RMI_ADDR);
  wire st_rmi_add1 = (step_q == add_seq_pkg::S_RMI_ADD1);
  wire st_rmi_pc   = (step_q == add_seq_pkg::S_RMI_PC);
  wire st_rmi_add2 = (step_q == add_seq_pkg::S_RMI_ADD2);

  // ---------------------------------------------------------------
  // Mapping lookup and sequencing
  // ---------------------------------------------------------------
  // Opcode map; unknown opcodes park in an illegal step then refetch
  add_seq_pkg::step_t map_start;
  always_comb begin
    if (op_f == add_seq_pkg::OP_ADD_RR) begin
      map_start = add_seq_pkg::S_RR_EX;
    end else if (op_f == add_seq_pkg::OP_ADD_RM) begin
      map_start = add_seq_pkg::S_RM_ADDR;
    end else if (op_f == add_seq_pkg::OP_ADD_MM) begin
      map_start = add_seq_pkg::S_MM_ADDR2;
    end else if (op_f == add_seq_pkg::OP_ADD_RS) begin
      map_start = add_seq_pkg::S_RS_EX;
    end else if (op_f == add_seq_pkg::OP_ADD_RX) begin
      map_start = add_seq_pkg::S_RX_PC;
    end else if (op_f == add_seq_pkg::OP_ADD_RMI) begin
      map_start = add_seq_pkg::S_RMI_ADDR;
    end else begin
      map_start = add_seq_pkg::S_ILLEGAL;
    end
  end

  // Next step: each routine ends by returning to fetch
  always_comb begin
    case (step_q)
      // Fetch routine: counter out, instruction in, then the map
      add_seq_pkg::S_FETCH0: begin
        step_d = add_seq_pkg::S_FETCH1;
      end
      add_seq_pkg::S_FETCH1: begin
        step_d = add_seq_pkg::S_DECODE;
      end
      add_seq_pkg::S_DECODE: begin
        step_d = map_start;
      end
      // Register-to-memory-reference: address, then add
      add_seq_pkg::S_RM_ADDR: begin
        step_d = add_seq_pkg::S_RM_ADD;
      end
      // Memory-to-memory: two operand fetches, then write-back
      add_seq_pkg::S_MM_ADDR2: begin
        step_d = add_seq_pkg::S_MM_LDQ;
      end
      add_seq_pkg::S_MM_LDQ: begin
        step_d = add_seq_pkg::S_MM_ADDR1;
      end
      add_seq_pkg::S_MM_ADDR1: begin
        step_d = add_seq_pkg::S_MM_ADDQ;
      end
      add_seq_pkg::S_MM_ADDQ: begin
        step_d = add_seq_pkg::S_MM_WR;
      end
      // Register-to-indexed-memory: second word, address sum, add
      add_seq_pkg::S_RX_PC: begin
        step_d = add_seq_pkg::S_RX_IDX;
      end
      add_seq_pkg::S_RX_IDX: begin
        step_d = add_seq_pkg::S_RX_ADD;
      end
      // Register-to-memory-immediate: indexed add, then data word add
      add_seq_pkg::S_RMI_ADDR: begin
        step_d = add_seq_pkg::S_RMI_ADD1;
      end
      add_seq_pkg::S_RMI_ADD1: begin
        step_d = add_seq_pkg::S_RMI_PC;
      end
      add_seq_pkg::S_RMI_PC: begin
        step_d = add_seq_pkg::S_RMI_ADD2;
      end
      // Last steps and the illegal step all go back to fetch
      // so a bad opcode costs one cycle and never hangs the machine
      default: begin
        step_d = add_seq_pkg::S_FETCH0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Datapath controls
  // ---------------------------------------------------------------
  // Address latch source: direct register data or the ALU result
  wire mal_from_db  = st_fetch0
                   || st_rm_addr
                   || st_mm_addr2
                   || st_mm_addr1
                   || st_rx_pc
                   || st_rmi_addr
                   || st_rmi_pc;
  wire mal_from_alu = st_rx_idx;
  // The counter is bumped in every step that sends it to the latch
  wire pc_inc       = st_fetch0
                   || st_rx_pc
                   || st_rmi_pc;
  wire r1_mem_add   = st_rm_add
                   || st_rx_add
                   || st_rmi_add1
                   || st_rmi_add2;
  wire rd_step      = st_fetch1
                   || r1_mem_add
                   || st_mm_ldq
                   || st_mm_addq
                   || st_rx_idx;
  wire wr_step      = st_mm_wr;

  // Direct register data for address steps
  logic [15:0] db_val;
  always_comb begin
    case (step_q)
      // Index register chosen by the second field
      add_seq_pkg::S_RM_ADDR, add_seq_pkg::S_MM_ADDR2,
      add_seq_pkg::S_RMI_ADDR: begin
        db_val = x2_val;
      end
      // Index register chosen by the first field
      add_seq_pkg::S_MM_ADDR1: begin
        db_val = x1_val;
      end
      // Counter for the fetch and second-word steps
      default: begin
        db_val = pc_val;
      end
    endcase
  end

  // ALU adder: one operand pair per step
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  always_comb begin
    case (step_q)
      // Register-to-register: both operands from the field registers
      add_seq_pkg::S_RR_EX: begin
        alu_a = r1_val;
        alu_b = r2_val;
      end
      // Short immediate: the second field, zero-filled
      add_seq_pkg::S_RS_EX: begin
        alu_a = r1_val;
        alu_b = short_imm;
      end
      // Second memory operand is summed into the holding register
      add_seq_pkg::S_MM_ADDQ: begin
        alu_a = hold_q;
        alu_b = mem_in;
      end
      // Holding register passes through unchanged for the write-back
      add_seq_pkg::S_MM_WR: begin
        alu_a = hold_q;
        alu_b = add_seq_pkg::ZERO_WORD;
      end
      // Indexed address: index register plus the second instruction word
      add_seq_pkg::S_RX_IDX: begin
        alu_a = x2_val;
        alu_b = mem_in;
      end
      // Every other step adds the memory word into the first register
      default: begin
        alu_a = r1_val;
        alu_b = mem_in;
      end
    endcase
  end
  wire [15:0] alu_y = 16'(alu_a + alu_b);
  // First register is written by every add that lands in a register
  wire        r1_we = r1_mem_add
                   || st_rr_ex
                   || st_rs_ex;

  // ---------------------------------------------------------------
  // Register array; the counter is an ordinary entry
  // ---------------------------------------------------------------
  // R1 write wins over a counter bump only if R1 is the counter itself;
  // no step does both today, so the order only matters for new routines
  for (genvar i = 0; i < NREGS; i++) begin : g_reg
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        regs_q[i] <= add_seq_pkg::ZERO_WORD;
      end else if (r1_we && (first_register_field == 4'(i))) begin
        regs_q[i] <= alu_y;
      end else if (pc_inc && (add_seq_pkg::PC_REG_IDX == 4'(i))) begin
        regs_q[i] <= 16'(pc_val + 16'h0001);
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and latches
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      step_q <= add_seq_pkg::S_FETCH0;
    end else begin
      step_q <= step_d;
    end
  end

  // Address latch: loaded from register data or the ALU, else it holds,
  // which is what lets the write-back reuse the first index address
  wire [15:0] mal_d = mal_from_db  ? db_val
                    : mal_from_alu ? alu_y
                    : mal_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mal_q <= add_seq_pkg::ZERO_WORD;
    end else begin
      mal_q <= mal_d;
    end
  end

  // Instruction latch: loaded only in the fetch read step,
  // so second instruction words never disturb the decoded fields
  wire [15:0] ir_d = st_fetch1 ? mem_in : ir_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ir_q <= add_seq_pkg::ZERO_WORD;
    end else begin
      ir_q <= ir_d;
    end
  end

  // Holding register: first operand in, then the running sum;
  // it also feeds the memory write data
  wire [15:0] hold_d = st_mm_ldq  ? mem_in
                     : st_mm_addq ? alu_y
                     : hold_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_q <= add_seq_pkg::ZERO_WORD;
    end else begin
      hold_q <= hold_d;
    end
  end

  // Unknown opcode flag: refreshed at every decode, so it reports
  // only the latest instruction and clears itself on a good one
  wire illegal_d = st_decode ? (map_start == add_seq_pkg::S_ILLEGAL) : illegal_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Write data reflects the holding register so it is stable in the write step
  assign memory_address_latch      = mal_q;
  // Strobes follow the step register with no extra delay
  assign mem_rd                    = rd_step;
  assign mem_wr                    = wr_step;
  // The bus driver is enabled only in the write step
  assign mem_wr_oe                 = wr_step;
  assign mem_wr_data               = hold_q;
  // Status for the surrounding control unit
  assign instruction_holding_latch = ir_q;
  assign pipeline_step             = step_q;
  assign illegal_opcode            = illegal_q;
  assign program_counter           = pc_val;

endmodule // add_instruction_microsequencer
`default_nettype wire

// File: shared/add_seq_pkg.sv
package add_seq_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int WORD_W   = 16;
  localparam int REG_AW   = 4;
  localparam int OP_W     = 8;

  // ---------------------------------------------------------------
  // Instruction field positions (opcode in the high byte)
  // ---------------------------------------------------------------
  localparam int OP_MSB   = 15;
  localparam int OP_LSB   = 8;
  localparam int F1_MSB   = 7;
  localparam int F1_LSB   = 4;
  localparam int F2_MSB   = 3;
  localparam int F2_LSB   = 0;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ADD_RR  = 8'h01;
  localparam logic [7:0] OP_ADD_RM  = 8'h02;
  localparam logic [7:0] OP_ADD_MM  = 8'h03;
  localparam logic [7:0] OP_ADD_RS  = 8'h04;
  localparam logic [7:0] OP_ADD_RX  = 8'h05;
  localparam logic [7:0] OP_ADD_RMI = 8'h06;

  // ---------------------------------------------------------------
  // Register used as program counter, reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  PC_REG_IDX = 4'hF;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;

  // Microsteps
  typedef enum logic [4:0] {
    S_FETCH0, S_FETCH1, S_DECODE,
    S_RR_EX,
    S_RM_ADDR, S_RM_ADD,
    S_MM_ADDR2, S_MM_LDQ, S_MM_ADDR1, S_MM_ADDQ, S_MM_WR,
    S_RS_EX,
    S_RX_PC, S_RX_IDX, S_RX_ADD,
    S_RMI_ADDR, S_RMI_ADD1, S_RMI_PC, S_RMI_ADD2,
    S_ILLEGAL
  } step_t;

endpackage

// File: verif/add_seq_chk.sv
`timescale 1ns/1ns
`default_nettype none
module add_seq_chk #(
  parameter int NREGS = 16
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [15:0] memory_address_latch,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        mem_wr_oe,
  input wire logic [15:0] instruction_holding_latch,
  input wire logic [4:0]  pipeline_step,
  input wire logic        illegal_opcode,
  input wire logic [15:0] program_counter
);
  // ---------------------------------------------------------------
  // Step decodes
  // ---------------------------------------------------------------
  // Steps that copy the counter to the latch and bump it
  wire       bump_step = pipeline_step inside {add_seq_pkg::S_FETCH0, add_seq_pkg::S_RX_PC, add_seq_pkg::S_RMI_PC};
  wire       last_step = pipeline_step inside {add_seq_pkg::S_RR_EX, add_seq_pkg::S_RS_EX, add_seq_pkg::S_RX_ADD};
  wire       wr_step   = pipeline_step == add_seq_pkg::S_MM_WR;
  wire [7:0] opcode    = instruction_holding_latch[15:8];
  wire       known_op  = opcode inside {[add_seq_pkg::OP_ADD_RR:add_seq_pkg::OP_ADD_RMI]};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_pc_bump; bump_step |=> memory_address_latch == $past(program_counter)
    && program_counter == $past(program_counter) + 16'h0001; endproperty
  a_pc_bump: assert property (p_pc_bump) else $error("counter not copied and bumped");
  property p_fetch_rd; pipeline_step == add_seq_pkg::S_FETCH1 |-> mem_rd ##1 pipeline_step == add_seq_pkg::S_DECODE;
  endproperty
  a_fetch_rd: assert property (p_fetch_rd) else $error("fetch read step wrong");
  property p_map_mm; pipeline_step == add_seq_pkg::S_DECODE && opcode == add_seq_pkg::OP_ADD_MM
    |=> pipeline_step == add_seq_pkg::S_MM_ADDR2; endproperty
  a_map_mm: assert property (p_map_mm) else $error("opcode mapped to wrong step");
  property p_rm_len; pipeline_step == add_seq_pkg::S_RM_ADDR |=> pipeline_step == add_seq_pkg::S_RM_ADD
    ##1 pipeline_step == add_seq_pkg::S_FETCH0; endproperty
  a_rm_len: assert property (p_rm_len) else $error("memory reference length wrong");
  property p_mm_seq; pipeline_step == add_seq_pkg::S_MM_ADDR2 |=> pipeline_step == add_seq_pkg::S_MM_LDQ
    ##1 pipeline_step == add_seq_pkg::S_MM_ADDR1 ##1 pipeline_step == add_seq_pkg::S_MM_ADDQ
    ##1 wr_step ##1 pipeline_step == add_seq_pkg::S_FETCH0; endproperty
  a_mm_seq: assert property (p_mm_seq) else $error("memory to memory order wrong");
  // Write-back reuses the latch left by the first index step
  property p_wr_addr; wr_step |-> $stable(memory_address_latch); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("latch moved before write");
  property p_bus_oe; mem_wr_oe == wr_step && mem_wr == wr_step; endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus driven outside write step");
  property p_done; last_step |=> pipeline_step == add_seq_pkg::S_FETCH0; endproperty
  a_done: assert property (p_done) else $error("no return to fetch");
  property p_illegal; pipeline_step == add_seq_pkg::S_DECODE && !known_op |=> illegal_opcode
    && pipeline_step == add_seq_pkg::S_ILLEGAL ##1 pipeline_step == add_seq_pkg::S_FETCH0; endproperty
  a_illegal: assert property (p_illegal) else $error("unknown opcode not refused");
endmodule // add_seq_chk
`default_nettype wire

// File: verif/main_memory_model.sv
`timescale 1ns/1ns
`default_nettype none
module main_memory_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] memory_address_latch,
  input  wire logic        mem_wr,
  input  wire logic        mem_wr_oe,
  input  wire logic [15:0] mem_wr_data,
  output logic [15:0]      mem_rd_data
);
  // Only 1K words are backed; upper address bits alias
  logic [15:0] mem [0:1023];

  // Reads are steady for as long as the latch holds its address
  assign mem_rd_data = mem[memory_address_latch[9:0]];

  // Data is taken only while the block really drives the bus
  always @(posedge sys_clk) begin
    if (mem_wr && mem_wr_oe) begin
      mem[memory_address_latch[9:0]] <= mem_wr_data;
    end
  end
endmodule // main_memory_model
`default_nettype wire

// File: verif/test_add_instruction_microsequencer.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module test_add_instruction_microsequencer;
  logic        sys_clk, srst, mem_wr, mem_wr_oe, mem_rd, illegal_opcode, ill_seen;
  logic [15:0] mem_rd_data, memory_address_latch, mem_wr_data, instruction_holding_latch, program_counter, rx_addr;
  logic [4:0]  pipeline_step;
  logic [15:0] wa[$], wd[$], wpc[$];
  int          fail_count, comparisons;
  // Program: loads r2, r1, then every addressing mode, a jump through the counter and an unknown opcode
  localparam logic [15:0] PROG [0:9] = '{16'h042F, 16'h042F, 16'h0415, 16'h0112, 16'h0242,
                                         16'h0312, 16'h0542, 16'h0005, 16'h0642, 16'h0010};
  add_instruction_microsequencer #(.NREGS(16)) add_instruction_microsequencer_inst (.sys_clk(sys_clk), .srst(srst),
    .mem_rd_data(mem_rd_data), .memory_address_latch(memory_address_latch), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wr_data(mem_wr_data), .mem_wr_oe(mem_wr_oe), .instruction_holding_latch(instruction_holding_latch),
    .pipeline_step(pipeline_step), .illegal_opcode(illegal_opcode), .program_counter(program_counter));
  main_memory_model main_memory_model_inst (.sys_clk(sys_clk), .memory_address_latch(memory_address_latch),
    .mem_wr(mem_wr), .mem_wr_oe(mem_wr_oe), .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data));

  // ---------------------------------------------------------------
  // Clock and bus watcher
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Writes and the indexed address are logged so the sequence can be judged later
  always @(posedge sys_clk) begin
    if (!srst && mem_wr) begin
      wa.push_back(memory_address_latch);
      wd.push_back(mem_wr_data);
      wpc.push_back(program_counter);
    end
    if (pipeline_step === add_seq_pkg::S_RX_ADD) rx_addr <= memory_address_latch;
    if (illegal_opcode === 1'b1) ill_seen <= 1'b1;
  end

  task automatic results();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    srst = 1'b1;
    ill_seen = 1'b0;
    rx_addr = 16'h0000;
    fail_count = 0;
    comparisons = 0;
    for (int i = 0; i < 1024; i++) main_memory_model_inst.mem[i] = 16'hFF00;
    for (int i = 0; i < 10; i++) main_memory_model_inst.mem[i] = PROG[i];
    main_memory_model_inst.mem[16'h00A] = 16'h01F4;
    main_memory_model_inst.mem[16'h01E] = 16'h0030;
    main_memory_model_inst.mem[16'h023] = 16'h0100;
    main_memory_model_inst.mem[16'h1AC] = 16'h04F3;
    main_memory_model_inst.mem[16'h1B0] = 16'h0310;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    n = 0;
    while (wa.size() < 2 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      results();
    end
    // Let the memory write of that same edge settle before reading it back
    #1;
    // First write: memory to memory adds [0x1E] into [r1] at the same address
    `CHK(wa[0], 16'h0023)
    `CHK(wd[0], 16'h0130)
    // Indexed address is r2 plus the second word
    `CHK(rx_addr, 16'h0023)
    `CHK(ill_seen, 1'b1)
    // Counter jumped via register add, then short immediate of 3
    `CHK(wpc[1], 16'h01B1)
    // Second write adds the word at [r0] = address 0 to the first write's sum still held at 0x23
    `CHK(wa[1], 16'h0023)
    `CHK(wd[1], 16'h055F)
    `CHK(main_memory_model_inst.mem[16'h023], 16'h055F)
    // Reset in mid-run puts the sequencer back at the first fetch
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(program_counter, add_seq_pkg::PC_RESET)
    `CHK(pipeline_step, add_seq_pkg::S_FETCH0)
    `CHK(illegal_opcode, 1'b0)
    results();
  end
endmodule // test_add_instruction_microsequencer
bind add_instruction_microsequencer add_seq_chk #(.NREGS(NREGS)) add_seq_chk_inst (.sys_clk(sys_clk), .srst(srst),
  .memory_address_latch(memory_address_latch), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wr_oe(mem_wr_oe),
  .instruction_holding_latch(instruction_holding_latch), .pipeline_step(pipeline_step),
  .illegal_opcode(illegal_opcode), .program_counter(program_counter));
`default_nettype wire
